// file: src/bcd_step_unit.sv
// Saturating packed-BCD add or subtract of one step
module bcd_step_unit #(
	parameter int unsigned DIGITS = 6 // Decimal digits
) (
	input wire logic [4*DIGITS-1:0] value, // Current value
	input wire logic [4*DIGITS-1:0] step, // Step size
	input wire logic up, // High adds, low subtracts
	output logic [4*DIGITS-1:0] result // Clamped result
);
	logic [DIGITS:0] carry;
	logic [4*DIGITS-1:0] raw;

	assign carry[0] = ~up;
	for (genvar i = 0; i < DIGITS; i++) begin : g_digit
		logic [3:0] b;
		logic [4:0] sum;
		// Nines complement turns subtraction into addition
		assign b = up ? step[4*i +: 4] : 4'h9 - step[4*i +: 4];
		assign sum = {1'b0, value[4*i +: 4]} + {1'b0, b} + {4'h0, carry[i]};
		assign carry[i+1] = sum > 5'h09;
		assign raw[4*i +: 4] = carry[i+1] ? 4'(sum - 5'h0A) : sum[3:0];
	end
	// Overflow pins to all nines, borrow pins to zero
	assign result = (up & carry[DIGITS]) ? {DIGITS{4'h9}} : (~up & ~carry[DIGITS]) ? '0 : raw;
endmodule

// file: src/remote_tuning_ctrl.sv
// Remote serial tuning control: APB registers, serial transfers, slews
module remote_tuning_ctrl #(
	parameter int unsigned STEP_CYCLES = tuning_ctrl_pkg::STEP_CYCLES // Cycles per slew step
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, low
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic irq, // Interrupt, high
	input wire logic link_clk, // Serial link clock
	input wire logic ser_data_in, // Serial data in
	input wire logic write_tuning_transfer, // Write frame
	input wire logic read_tuning_transfer, // Read-back frame
	input wire logic seek_up, // Seek slew up
	input wire logic seek_down, // Seek slew down
	input wire logic pulse_up, // Count-pulse slew up
	input wire logic pulse_down, // Count-pulse slew down
	input wire logic count_pulse, // Count pulse
	input wire logic [7:0] signal_level, // Signal strength
	output logic ser_data_out, // Serial data out
	output logic remote_mode_flag_out, // Remote mode status
	output logic signal_found_out, // Signal found status
	output tuning_ctrl_pkg::tune_msg_t tuning_out, // Current tuning
	output logic [4:0] detect_select // One-hot detector select
);
	localparam logic [tuning_ctrl_pkg::TIMER_W-1:0] STEP_LOAD = tuning_ctrl_pkg::TIMER_W'(STEP_CYCLES - 1);

	// ========================================
	// Input synchronisation
	tuning_ctrl_pkg::link_in_t raw_in;
	tuning_ctrl_pkg::link_in_t s;
	tuning_ctrl_pkg::link_in_t prev;

	assign raw_in = '{link_clk, ser_data_in, write_tuning_transfer, read_tuning_transfer,
		'{seek_up, seek_down, pulse_up, pulse_down, count_pulse}};

	sync_bank #(
		.W($bits(tuning_ctrl_pkg::link_in_t))
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(raw_in),
		.q(s)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= '0;
		end else begin
			prev <= s;
		end
	end

	logic link_rise;
	logic link_fall;
	logic wr_start;
	logic rd_start;
	logic cnt_edge;
	assign link_rise = s.link_clk & ~prev.link_clk;
	assign link_fall = ~s.link_clk & prev.link_clk;
	assign wr_start = s.wr_frame & ~prev.wr_frame;
	assign rd_start = s.rd_frame & ~prev.rd_frame;
	assign cnt_edge = s.slew.count & ~prev.slew.count;

	// ========================================
	// Registers
	logic ctrl_remote;
	logic [7:0] thr;
	tuning_ctrl_pkg::tune_msg_t tune;
	logic [tuning_ctrl_pkg::EV_W-1:0] int_status;
	logic [tuning_ctrl_pkg::EV_W-1:0] int_mask;

	// ========================================
	// APB slave
	logic acc;
	logic wr_done;
	logic sel_ctrl;
	logic sel_status;
	logic sel_tune;
	logic sel_int;
	logic sel_mask;
	logic addr_hit;
	logic [31:0] rd_data;
	logic [31:0] status_word;
	assign acc = psel & penable;
	assign wr_done = acc & pready & pwrite;
	assign sel_ctrl = paddr == tuning_ctrl_pkg::ADDR_CTRL;
	assign sel_status = paddr == tuning_ctrl_pkg::ADDR_STATUS;
	assign sel_tune = paddr == tuning_ctrl_pkg::ADDR_TUNE;
	assign sel_int = paddr == tuning_ctrl_pkg::ADDR_INT_STATUS;
	assign sel_mask = paddr == tuning_ctrl_pkg::ADDR_INT_MASK;
	assign addr_hit = sel_ctrl | sel_status | sel_tune | sel_int | sel_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & ~addr_hit;
			prdata <= (acc & ~pready & ~pwrite) ? rd_data : '0;
		end
	end

	// ========================================
	// Serial transfer engine
	tuning_ctrl_pkg::link_state_t state;
	tuning_ctrl_pkg::link_state_t next_state;
	logic [31:0] shreg;
	logic [31:0] next_shreg;
	logic [5:0] bit_cnt;
	logic write_go;
	logic read_go;
	logic shift_in;
	logic shift_out;
	logic wr_end;
	logic wr_ok;
	logic wr_bad;
	assign write_go = wr_start & ctrl_remote;
	assign read_go = rd_start & ~write_go;
	assign shift_in = (state == tuning_ctrl_pkg::L_WRITE) && link_rise
		&& (bit_cnt != tuning_ctrl_pkg::BIT_COUNT_FULL);
	assign shift_out = (state == tuning_ctrl_pkg::L_READ) && link_fall;
	assign wr_end = (state == tuning_ctrl_pkg::L_WRITE) && !s.wr_frame;
	// Whole message with odd parity, still remote at frame end
	assign wr_ok = wr_end && (bit_cnt == tuning_ctrl_pkg::BIT_COUNT_FULL) && (^shreg) && ctrl_remote;
	assign wr_bad = wr_end && !wr_ok;
	// Both directions shift right, bit 0 first
	assign next_shreg = (state == tuning_ctrl_pkg::L_IDLE && read_go) ? tune :
		shift_in ? {s.ser_data, shreg[31:1]} :
		shift_out ? {1'b0, shreg[31:1]} : shreg;

	always_comb begin
		next_state = state;
		unique case (state)
			tuning_ctrl_pkg::L_IDLE: begin
				if (write_go) begin
					next_state = tuning_ctrl_pkg::L_WRITE;
				end else if (read_go) begin
					next_state = tuning_ctrl_pkg::L_READ;
				end
			end
			tuning_ctrl_pkg::L_WRITE: begin
				if (wr_end) begin
					next_state = tuning_ctrl_pkg::L_IDLE;
				end
			end
			tuning_ctrl_pkg::L_READ: begin
				if (!s.rd_frame) begin
					next_state = tuning_ctrl_pkg::L_IDLE;
				end
			end
			default: next_state = tuning_ctrl_pkg::L_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= tuning_ctrl_pkg::L_IDLE;
			shreg <= '0;
			bit_cnt <= '0;
			ser_data_out <= 1'b0;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			bit_cnt <= (state == tuning_ctrl_pkg::L_IDLE) ? 6'h00 : bit_cnt + 6'(shift_in);
			ser_data_out <= (next_state == tuning_ctrl_pkg::L_READ) & next_shreg[0];
		end
	end

	// ========================================
	// Slew control
	logic seek_act;
	logic pulse_act;
	logic slew_act;
	logic dir_up;
	logic seek_was;
	logic [tuning_ctrl_pkg::TIMER_W-1:0] timer;
	logic step_req;
	logic at_limit;
	logic step_apply;
	logic edge_event;
	logic edge_hit;
	logic found_eval;
	logic next_found;
	logic [23:0] stepped_freq;
	// Slews only in remote mode, opposite lines together cancel
	assign seek_act = ctrl_remote & (s.slew.seek_up ^ s.slew.seek_down);
	assign pulse_act = ctrl_remote & ~seek_act & (s.slew.pulse_up ^ s.slew.pulse_down);
	assign slew_act = seek_act | pulse_act;
	assign dir_up = seek_act ? s.slew.seek_up : s.slew.pulse_up;
	// Seek steps on timer expiry; pulses only once the holdoff has run out
	assign step_req = seek_act ? (seek_was && timer == '0) : (pulse_act && cnt_edge && timer == '0);
	assign at_limit = dir_up ? (tune.freq == tuning_ctrl_pkg::FREQ_MAX) : (tune.freq == tuning_ctrl_pkg::FREQ_MIN);
	assign step_apply = step_req & ~edge_hit & ~at_limit & ~wr_ok;
	assign edge_event = step_req & ~edge_hit & at_limit;
	assign next_found = !slew_act ? 1'b0 : found_eval ? (signal_level >= thr) : signal_found_out;

	bcd_step_unit #(
		.DIGITS(tuning_ctrl_pkg::FREQ_DIGITS)
	) u_step (
		.value(tune.freq),
		.step(tuning_ctrl_pkg::step_size(tune.filter_width_field)),
		.up(dir_up),
		.result(stepped_freq)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seek_was <= 1'b0;
			timer <= '0;
			edge_hit <= 1'b0;
			found_eval <= 1'b0;
			signal_found_out <= 1'b0;
		end else begin
			seek_was <= seek_act;
			if (!slew_act) begin
				timer <= '0;
			end else if ((seek_act & ~seek_was) | step_req) begin
				timer <= STEP_LOAD;
			end else if (timer != '0) begin
				timer <= timer - 1'b1;
			end
			edge_hit <= slew_act & (edge_hit | edge_event);
			found_eval <= step_apply;
			signal_found_out <= next_found;
		end
	end

	// ========================================
	// Tuning state
	tuning_ctrl_pkg::tune_msg_t stepped_tune;
	tuning_ctrl_pkg::tune_msg_t next_tune;
	logic apb_tune_wr;
	assign stepped_tune = '{1'b0, tune.filter_width_field, stepped_freq, tune.spare, tune.mode};
	assign apb_tune_wr = wr_done & sel_tune & ~ctrl_remote;
	// Rejected writes leave the previous settings in place
	assign next_tune = tuning_ctrl_pkg::with_parity(wr_ok ? shreg :
		step_apply ? stepped_tune : apb_tune_wr ? pwdata : tune);
	assign tuning_out = tune;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune <= tuning_ctrl_pkg::TUNE_RESET;
			detect_select <= 5'h01;
		end else begin
			tune <= next_tune;
			detect_select <= tuning_ctrl_pkg::mode_select(next_tune.mode);
		end
	end

	// ========================================
	// Control, status and interrupts
	logic [tuning_ctrl_pkg::EV_W-1:0] events;
	logic [tuning_ctrl_pkg::EV_W-1:0] clear_bits;
	logic [tuning_ctrl_pkg::EV_W-1:0] next_int;
	logic [tuning_ctrl_pkg::EV_W-1:0] next_mask;
	logic next_remote;
	assign events = {edge_event, next_found & ~signal_found_out, wr_bad, wr_ok};
	assign clear_bits = (wr_done & sel_int) ? pwdata[tuning_ctrl_pkg::EV_W-1:0] : '0;
	// New events win over a clear in the same cycle
	assign next_int = (int_status & ~clear_bits) | events;
	assign next_mask = (wr_done & sel_mask) ? pwdata[tuning_ctrl_pkg::EV_W-1:0] : int_mask;
	assign next_remote = (wr_done & sel_ctrl) ? pwdata[tuning_ctrl_pkg::CTRL_REMOTE] : ctrl_remote;
	assign status_word = {27'h0000000, state != tuning_ctrl_pkg::L_IDLE, edge_hit, slew_act,
		signal_found_out, ctrl_remote};
	assign rd_data = sel_ctrl ? {16'h0000, thr, 7'h00, ctrl_remote} :
		sel_status ? status_word :
		sel_tune ? tune :
		sel_int ? {28'h0000000, int_status} :
		sel_mask ? {28'h0000000, int_mask} : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_remote <= 1'b0;
			thr <= tuning_ctrl_pkg::THR_RESET;
			int_status <= '0;
			int_mask <= '0;
			irq <= 1'b0;
			remote_mode_flag_out <= 1'b0;
		end else begin
			ctrl_remote <= next_remote;
			if (wr_done & sel_ctrl) begin
				thr <= pwdata[tuning_ctrl_pkg::CTRL_THR_LSB +: 8];
			end
			int_status <= next_int;
			int_mask <= next_mask;
			irq <= |(next_int & next_mask);
			remote_mode_flag_out <= next_remote;
		end
	end

	// ========================================
	// Assertions
	logic [tuning_ctrl_pkg::TIMER_W-1:0] since_step;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_step <= '0;
		end else if (!slew_act) begin
			since_step <= STEP_LOAD;
		end else if (step_apply) begin
			since_step <= '0;
		end else if (since_step != STEP_LOAD) begin
			since_step <= since_step + 1'b1;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_remote_flag;
		remote_mode_flag_out == ctrl_remote;
	endproperty
	a_remote_flag: assert property (p_remote_flag) else $error("remote flag differs from mode");
	property p_local_idle;
		!remote_mode_flag_out |-> !wr_ok && !step_apply && !write_go;
	endproperty
	a_local_idle: assert property (p_local_idle) else $error("write or slew acted in local mode");
	property p_read_any;
		state == tuning_ctrl_pkg::L_IDLE && read_go |=> state == tuning_ctrl_pkg::L_READ && shreg == $past(tune);
	endproperty
	a_read_any: assert property (p_read_any) else $error("read-back not started");
	property p_odd_parity;
		^tune;
	endproperty
	a_odd_parity: assert property (p_odd_parity) else $error("stored message has even parity");
	property p_reject_even;
		wr_end && !(^shreg) && !step_apply && !apb_tune_wr |=> $stable(tune);
	endproperty
	a_reject_even: assert property (p_reject_even) else $error("even-parity write changed tuning");
	property p_step_gap;
		step_apply |-> since_step == STEP_LOAD;
	endproperty
	a_step_gap: assert property (p_step_gap) else $error("steps closer than step period");
	property p_no_wrap;
		step_apply |=> ($past(dir_up) ? tune.freq > $past(tune.freq) : tune.freq < $past(tune.freq));
	endproperty
	a_no_wrap: assert property (p_no_wrap) else $error("step wrapped or did not move");
	property p_found_cmp;
		slew_act && step_apply ##1 slew_act |=> signal_found_out == ($past(signal_level) >= $past(thr));
	endproperty
	a_found_cmp: assert property (p_found_cmp) else $error("found flag disagrees with threshold");
	property p_shift_order;
		shift_in |=> shreg[31] == $past(s.ser_data) && shreg[30:0] == $past(shreg[31:1]);
	endproperty
	a_shift_order: assert property (p_shift_order) else $error("write shift order wrong");
	property p_edge_stop;
		edge_hit |-> !step_apply;
	endproperty
	a_edge_stop: assert property (p_edge_stop) else $error("step after band edge");

	c_write_ok: cover property (wr_ok);
	c_read: cover property (state == tuning_ctrl_pkg::L_READ && shift_out);
	c_seek_step: cover property (seek_act && step_apply);
	c_pulse_step: cover property (pulse_act && step_apply);
	c_edge: cover property (edge_event);
endmodule

// file: src/sync_bank.sv
// Two-flop synchroniser bank for inputs from outside the pclk domain
module sync_bank #(
	parameter int unsigned W = 1 // Bits synchronised
) (
	input wire logic clk, // Sampling clock
	input wire logic rst_n, // Async reset, low
	input wire logic [W-1:0] d, // Raw inputs
	output logic [W-1:0] q // Synchronised inputs
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// file: src/tuning_ctrl_pkg.sv
// Constants, carriers and helpers of the remote serial tuning control
package tuning_ctrl_pkg;
	// ========================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned STEP_TIME_MS = 100;
	localparam int unsigned STEP_CYCLES = STEP_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 24;
	localparam int unsigned FREQ_DIGITS = 6;
	localparam logic [5:0] BIT_COUNT_FULL = 6'h20;
	// ========================================
	// Register map and fields
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TUNE = 8'h08;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_INT_MASK = 8'h10;
	localparam int unsigned CTRL_REMOTE = 0;
	localparam int unsigned CTRL_THR_LSB = 8;
	localparam logic [7:0] THR_RESET = 8'h80;
	localparam int unsigned ST_REMOTE = 0;
	localparam int unsigned ST_FOUND = 1;
	localparam int unsigned ST_SLEW = 2;
	localparam int unsigned ST_EDGE = 3;
	localparam int unsigned ST_LINK = 4;
	localparam int unsigned EV_W = 4;
	localparam logic [23:0] FREQ_MAX = 24'h999999;
	localparam logic [23:0] FREQ_MIN = 24'h000000;
	// ========================================
	// Carriers
	typedef struct packed {
		logic parity;
		logic [2:0] filter_width_field;
		logic [23:0] freq;
		logic spare;
		logic [2:0] mode;
	} tune_msg_t;
	typedef struct packed {
		logic seek_up;
		logic seek_down;
		logic pulse_up;
		logic pulse_down;
		logic count;
	} slew_t;
	typedef struct packed {
		logic link_clk;
		logic ser_data;
		logic wr_frame;
		logic rd_frame;
		slew_t slew;
	} link_in_t;
	typedef enum logic [2:0] {
		L_IDLE = 3'b001,
		L_WRITE = 3'b010,
		L_READ = 3'b100
	} link_state_t;
	localparam tune_msg_t TUNE_RESET = '{1'b0, 3'h0, 24'h000000, 1'b0, 3'h1};
	// ========================================
	// Helpers
	function automatic logic [23:0] step_size(input logic [2:0] width);
		case (width)
			3'h1: step_size = 24'h000003;
			3'h2: step_size = 24'h000010;
			3'h3: step_size = 24'h000022;
			3'h4: step_size = 24'h000032;
			3'h5: step_size = 24'h000060;
			default: step_size = 24'h000500;
		endcase
	endfunction
	function automatic logic [4:0] mode_select(input logic [2:0] mode);
		case (mode)
			3'h1: mode_select = 5'h01;
			3'h2: mode_select = 5'h02;
			3'h3: mode_select = 5'h04;
			3'h4: mode_select = 5'h08;
			default: mode_select = 5'h10;
		endcase
	endfunction
	function automatic tune_msg_t with_parity(input tune_msg_t m);
		with_parity = m;
		with_parity.parity = ~(^m[30:0]);
	endfunction
endpackage

// file: verification/remote_controller_model.sv
// Behavioural model of the external remote controller
module remote_controller_model (
	input wire logic pclk, // Block clock, paces slew lines
	input wire logic ser_data_out, // Serial read data from block
	output logic link_clk, // Link clock, still outside frames
	output logic ser_data_in, // Serial write data
	output logic write_tuning_transfer, // Write frame
	output logic read_tuning_transfer, // Read-back frame
	output tuning_ctrl_pkg::slew_t slew // Slew request and count lines
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_clk = 1'b0;
		ser_data_in = 1'b0;
		write_tuning_transfer = 1'b0;
		read_tuning_transfer = 1'b0;
		slew = '0;
	end
	// ========================================
	// Serial transfer, bit 0 first in both directions
	task automatic xfer(input logic rd, input logic [31:0] wm, output logic [31:0] rm);
		if (rd) begin
			read_tuning_transfer = 1'b1;
		end else begin
			write_tuning_transfer = 1'b1;
		end
		#200;
		for (int i = 0; i < 32; i++) begin
			ser_data_in = wm[i];
			#62.5 link_clk = 1'b1;
			rm[i] = ser_data_out;
			#62.5 link_clk = 1'b0;
		end
		#62.5;
		write_tuning_transfer = 1'b0;
		read_tuning_transfer = 1'b0;
		// Released line shows the inverse, not the last bit
		ser_data_in = ~ser_data_in;
		#200;
	endtask
	// ========================================
	// Slew lines and count pulses, moved on pclk edges
	task automatic set_slew(input logic [3:0] s);
		@(posedge pclk);
		slew <= {s, slew.count};
	endtask
	task automatic pulse();
		@(posedge pclk);
		slew.count <= 1'b1;
		repeat (5) @(posedge pclk);
		slew.count <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask
endmodule

// file: verification/test_remote_serial_tuning_control.sv
// Self-checking testbench of the remote serial tuning control
module test_remote_serial_tuning_control;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned STEP = 200;
	logic pclk;
	logic presetn;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [7:0] signal_level;
	logic [31:0] prdata;
	logic pready, pslverr, irq, link_clk, ser_data_in, wr_frame, rd_frame;
	logic ser_data_out, remote_flag, found;
	tuning_ctrl_pkg::slew_t slew;
	logic seek_up, seek_down, pulse_up, pulse_down, count_pulse;
	assign {seek_up, seek_down, pulse_up, pulse_down, count_pulse} = slew;
	tuning_ctrl_pkg::tune_msg_t tuning;
	logic [4:0] detect_select;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int comparisons = 0;
	logic [23:0] stp [8] = '{24'h000500, 24'h000003, 24'h000010, 24'h000022,
		24'h000032, 24'h000060, 24'h000500, 24'h000500};
	always #5 pclk = ~pclk;
	remote_tuning_ctrl #(.STEP_CYCLES(STEP)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .link_clk(link_clk),
		.ser_data_in(ser_data_in), .write_tuning_transfer(wr_frame),
		.read_tuning_transfer(rd_frame), .seek_up(seek_up), .seek_down(seek_down),
		.pulse_up(pulse_up), .pulse_down(pulse_down), .count_pulse(count_pulse),
		.signal_level(signal_level), .ser_data_out(ser_data_out),
		.remote_mode_flag_out(remote_flag), .signal_found_out(found), .tuning_out(tuning),
		.detect_select(detect_select));
	remote_controller_model u_ctl (.pclk(pclk), .ser_data_out(ser_data_out), .link_clk(link_clk),
		.ser_data_in(ser_data_in), .write_tuning_transfer(wr_frame),
		.read_tuning_transfer(rd_frame), .slew(slew));
	// ========================================
	// Shared helpers
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] mk(input logic [2:0] w, input logic [23:0] f, input logic [2:0] m);
		mk = {1'b0, w, f, 1'b0, m};
		mk[31] = ~(^mk[30:0]);
	endfunction
	function automatic logic [4:0] sel_of(input logic [2:0] m);
		sel_of = (m >= 3'h1 && m <= 3'h4) ? (5'h01 << (m - 3'h1)) : 5'h10;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset();
		chk("tuning", 32'h00000001, tuning);
		chk("detect", 32'h1, {27'h0, detect_select});
		chk("remote", 32'h0, {31'h0, remote_flag});
		apb(1'b0, tuning_ctrl_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h00008000, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		$display("test reset done");
	endtask
	task automatic t_local();
		u_ctl.xfer(1'b0, mk(3'h2, 24'h123456, 3'h2), rd);
		chk("local write", 32'h00000001, tuning);
		u_ctl.set_slew(4'b1000);
		cyc(STEP + 10);
		chk("local seek", 32'h00000001, tuning);
		u_ctl.set_slew(4'b0000);
		u_ctl.xfer(1'b1, 32'h0, rd);
		chk("local read", 32'h00000001, rd);
		$display("test local done");
	endtask
	task automatic t_codes();
		logic [31:0] m;
		apb(1'b1, tuning_ctrl_pkg::ADDR_CTRL, 32'h00008001);
		cyc(1);
		chk("remote", 32'h1, {31'h0, remote_flag});
		for (int i = 0; i < 8; i++) begin
			m = mk(i[2:0], 24'h100000, i[2:0]);
			u_ctl.xfer(1'b0, m, rd);
			chk("tuning", m, tuning);
			chk("detect", {27'h0, sel_of(i[2:0])}, {27'h0, detect_select});
			u_ctl.set_slew(4'b0010);
			u_ctl.pulse();
			cyc(4);
			chk("pulse step", {8'h0, 24'h100000 + stp[i]}, {8'h0, tuning.freq});
			chk("found", 32'h1, {31'h0, found});
			u_ctl.set_slew(4'b0000);
		end
		u_ctl.xfer(1'b1, 32'h0, rd);
		chk("read back", mk(3'h7, 24'h100500, 3'h7), rd);
		chk("read parity", 32'h1, {31'h0, ^rd});
		$display("test codes done");
	endtask
	task automatic t_reject();
		logic [31:0] m;
		m = mk(3'h1, 24'h000000, 3'h1);
		apb(1'b1, tuning_ctrl_pkg::ADDR_INT_STATUS, 32'h0000000F);
		u_ctl.xfer(1'b0, m ^ 32'h80000000, rd);
		chk("even parity", mk(3'h7, 24'h100500, 3'h7), tuning);
		apb(1'b0, tuning_ctrl_pkg::ADDR_INT_STATUS, 32'h0);
		chk("reject event", 32'h2, rd & 32'h3);
		u_ctl.xfer(1'b0, m, rd);
		chk("accept", m, tuning);
		$display("test reject done");
	endtask
	task automatic t_seek();
		u_ctl.set_slew(4'b1000);
		cyc(STEP + 10);
		chk("seek step", 32'h000003, {8'h0, tuning.freq});
		chk("found", 32'h1, {31'h0, found});
		u_ctl.set_slew(4'b0000);
		cyc(STEP + 10);
		chk("seek stopped", 32'h000003, {8'h0, tuning.freq});
		apb(1'b1, tuning_ctrl_pkg::ADDR_INT_MASK, 32'h00000008);
		apb(1'b1, tuning_ctrl_pkg::ADDR_INT_STATUS, 32'h0000000F);
		u_ctl.set_slew(4'b0100);
		cyc(2 * STEP + 20);
		chk("edge stop", 32'h000000, {8'h0, tuning.freq});
		chk("irq", 32'h1, {31'h0, irq});
		u_ctl.set_slew(4'b0000);
		apb(1'b1, tuning_ctrl_pkg::ADDR_INT_STATUS, 32'h00000008);
		cyc(2);
		chk("irq clear", 32'h0, {31'h0, irq});
		$display("test seek done");
	endtask
	task automatic t_burst();
		signal_level <= 8'h7F;
		cyc(STEP);
		u_ctl.set_slew(4'b0001);
		u_ctl.pulse();
		u_ctl.pulse();
		cyc(4);
		chk("burst", 32'h000000, {8'h0, tuning.freq});
		u_ctl.set_slew(4'b0000);
		cyc(4);
		u_ctl.set_slew(4'b0010);
		u_ctl.pulse();
		u_ctl.pulse();
		cyc(4);
		chk("burst", 32'h000003, {8'h0, tuning.freq});
		chk("no found", 32'h0, {31'h0, found});
		cyc(STEP);
		u_ctl.pulse();
		cyc(4);
		chk("spaced", 32'h000006, {8'h0, tuning.freq});
		u_ctl.set_slew(4'b0000);
		apb(1'b1, tuning_ctrl_pkg::ADDR_CTRL, 32'h00008000);
		cyc(1);
		chk("local", 32'h0, {31'h0, remote_flag});
		$display("test burst done");
	endtask
	// ========================================
	// Verdict and run control
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h00000000;
		signal_level = 8'h80;
		cyc(12);
		presetn <= 1'b1;
		cyc(1);
		t_reset();
		t_local();
		t_codes();
		t_reject();
		t_seek();
		t_burst();
		finish_test();
	end
endmodule
